// File: hdl/ger_pkg.sv
// Shared constants, types and state codes of the global event and command register block.
// Assumes a single PCI-side clock and a register access port driven by the PCI target logic.
package ger_pkg;

   // Register offsets within the slave register window.
   localparam logic [7:0]  OFS_COMMAND    = 8'h04;
   localparam logic [7:0]  OFS_STATUS     = 8'h08;  // Status on read, acknowledge on write.
   localparam logic [7:0]  OFS_MASK       = 8'h0C;
   localparam logic [7:0]  OFS_PQ_BASE    = 8'h14;
   localparam logic [7:0]  OFS_PQ_LENGTH  = 8'h18;

   // Reset values and implemented-bit masks.
   localparam logic [15:0] MASK_RESET     = 16'hFF7F;
   localparam logic [15:0] STAT_IMPL      = 16'hFF7F;
   localparam logic [15:0] FLAGS_CLEAR    = 16'h0000;
   localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
   localparam logic [1:0]  DWORD_ALIGN    = 2'b00;

   // Event flag positions; bits 7:0 are standalone flags with no queue entry.
   localparam int unsigned BIT_PCM_OK     = 0;
   localparam int unsigned BIT_PCM_FAIL   = 1;
   localparam int unsigned BIT_LB_OK      = 2;
   localparam int unsigned BIT_LB_FAIL    = 3;
   localparam int unsigned BIT_RX_ASYNC   = 4;
   localparam int unsigned BIT_TX_ASYNC   = 5;
   localparam int unsigned BIT_EXPIRED    = 6;
   localparam int unsigned BIT_PERIPH_LSB = 8;  // Line card, serial port, local bus, mailbox.
   localparam int unsigned BIT_LB_RX_Q    = 12;
   localparam int unsigned BIT_LB_TX_Q    = 13;
   localparam int unsigned BIT_PCM_RX_Q   = 14;
   localparam int unsigned BIT_PCM_TX_Q   = 15;

   // Command register fields.
   localparam int unsigned CMD_PCM_REQ    = 0;
   localparam int unsigned CMD_LB_REQ     = 1;
   localparam int unsigned CMD_RUN        = 4;
   localparam int unsigned CMD_RELOAD_LSB = 16;
   localparam int unsigned RELOAD_W       = 16;

   // Peripheral queue geometry.
   localparam int unsigned NUM_PERIPH     = 4;
   localparam int unsigned PQ_LEN_W       = 8;
   localparam int unsigned PQ_OFS_W       = 10;
   localparam logic [10:0] PQ_MAX_DWORDS  = 11'h400;
   localparam logic [1:0]  PQ_LEN_SHIFT   = 2'b00;  // Appended zeros: length times four.

   // Register access request from the PCI target.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } ger_reg_req_s;

   // One-cycle event pulses from the serial PCM core and the local bus interface.
   typedef struct packed {
      logic pcm_tx_entry;
      logic pcm_rx_entry;
      logic lb_tx_entry;
      logic lb_rx_entry;
      logic tx_async;
      logic rx_async;
   } ger_core_evt_s;

   typedef enum logic [2:0] {
      PQ_IDLE  = 3'b001,
      PQ_WRITE = 3'b010,
      PQ_WAIT  = 3'b100
   } ger_pq_state_e;

   typedef enum logic [2:0] {
      AR_IDLE = 3'b001,
      AR_LB   = 3'b010,
      AR_PCM  = 3'b100
   } ger_ar_state_e;

endpackage

// File: hdl/ger_countdown.sv
// Periodic count-down timer that pulses on every underflow while running.
// Assumes run and reload come from registers in the same clock domain.
`timescale 1ns/10ps
module ger_countdown #(
   parameter int unsigned W = 16
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Control.
   input  wire logic         run,
   input  wire logic [W-1:0] reload,
   // Event.
   output logic              expired
);
   import ger_pkg::*;

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic         run_ff;
   logic         expired_ff;
   logic         nxt_expired;

   // Load on the run edge, then count down and reload on underflow.
   always_comb begin
      nxt_cnt     = cnt_ff;
      nxt_expired = 1'b0;
      if (run && !run_ff) begin
         nxt_cnt = reload;
      end else if (run) begin
         if (cnt_ff == '0) begin
            nxt_expired = 1'b1;
            nxt_cnt     = reload;
         end else begin
            nxt_cnt = cnt_ff - W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff     <= '0;
         run_ff     <= 1'b0;
         expired_ff <= 1'b0;
      end else begin
         cnt_ff     <= nxt_cnt;
         run_ff     <= run;
         expired_ff <= nxt_expired;
      end
   end

   assign expired = expired_ff;

   // An underflow always leaves the counter holding the reload value.
   AST_RELOAD_AFTER_UNDERFLOW: assert property (
      @(posedge clk) disable iff (!rst_n)
      (run_ff && run && cnt_ff == '0) |=> (expired_ff && cnt_ff == $past(reload)))
      else $error("Timer did not reload after underflow.");

   // No underflow is reported while the timer is stopped.
   AST_QUIET_WHEN_STOPPED: assert property (
      @(posedge clk) disable iff (!rst_n)
      !run |=> !expired_ff)
      else $error("Timer expired while stopped.");

endmodule

// File: hdl/ger_global_regs.sv
// Global command, status, mask and peripheral queue registers with the host interrupt.
// Assumes register accesses, events and handshakes are synchronous to clk.
// Summary of operation
// - Every monitored event sets its own flag in the status register.
// - Any flagged, unmasked event asserts the host interrupt line.
// - Writing one to an acknowledge bit clears that flag, mask ignored.
// - Offset 08 reads status flags and writes the acknowledge logic.
// - A set mask bit blocks the interrupt but the flag still sets.
// - PCM transmit/receive queue flags set after their queue entry is written.
// - Local bus transmit/receive queue flags set after their queue entry is written.
// - Each peripheral source has its own flag, set after its queue entry.
// - Timer underflow sets the timer flag.
// - Missing transmit or receive frame pulse sets its asynchronous flag.
// - A finished local bus request sets exactly one of ok or fail.
// - A finished PCM request sets its ok or fail flag.
// - Status bits 7 to 0 are standalone and make no queue entry.
// - Peripheral queue base is dword aligned; its two low bits stay zero.
// - Peripheral queue length in dwords is four times the length field.
// - A length field of zero selects 1024 dwords.
// - After each entry the queue write pointer advances one dword.
// - At the queue end the pointer wraps to the base address.
`timescale 1ns/10ps
module ger_global_regs #(
   parameter int unsigned RELOAD_WIDTH = 16
) (
   // Clock and reset.
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   // Register access port.
   input  wire ger_pkg::ger_reg_req_s    reg_req,
   output logic [31:0]                   reg_rdata,
   output logic                          reg_rvalid,
   // Core events and peripheral entry requests.
   input  wire ger_pkg::ger_core_evt_s   core_evt,
   input  wire logic [3:0]               periph_evt,
   // Peripheral queue writer.
   output logic                          pq_wr_stb,
   output logic [31:0]                   pq_wr_addr,
   output logic [3:0]                    pq_wr_src,
   input  wire logic                     pq_wr_done,
   // Action request handshakes.
   output logic                          lb_action_req,
   input  wire logic                     lb_action_done,
   input  wire logic                     lb_action_ok,
   output logic                          pcm_action_req,
   input  wire logic                     pcm_action_done,
   input  wire logic                     pcm_action_ok,
   // Host interrupt, active low.
   output logic                          inta_n
);
   import ger_pkg::*;

   // Dword count of the peripheral queue for a length field.
   function automatic logic [10:0] queue_dwords(input logic [PQ_LEN_W-1:0] len);
      if (len == '0) begin
         queue_dwords = PQ_MAX_DWORDS;
      end else begin
         queue_dwords = {1'b0, len, PQ_LEN_SHIFT};
      end
   endfunction

   // Synchronised reset.
   logic rst_meta_ff;
   logic rst_n_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   // Register state.
   logic [15:0]             stat_ff,   nxt_stat;
   logic [15:0]             mask_ff,   nxt_mask;
   logic [31:0]             base_ff,   nxt_base;
   logic [PQ_LEN_W-1:0]     len_ff,    nxt_len;
   logic                    run_ff,    nxt_run;
   logic [RELOAD_WIDTH-1:0] reload_ff, nxt_reload;
   logic [31:0]             rdata_ff,  nxt_rdata;
   logic                    rvalid_ff;
   logic                    inta_n_ff;
   logic                    expired;
   logic [15:0]             set_vec;
   logic [15:0]             ack_vec;
   logic                    wr_cmd;

   // Queue writer state.
   ger_pq_state_e           pq_state_ff, nxt_pq_state;
   logic [NUM_PERIPH-1:0]   pend_ff,     nxt_pend;
   logic [NUM_PERIPH-1:0]   sel_ff,      nxt_sel;
   logic [PQ_OFS_W-1:0]     ofs_ff,      nxt_ofs;
   logic                    stb_ff,      nxt_stb;
   logic [31:0]             addr_ff,     nxt_addr;
   logic [10:0]             len_dwords;
   logic [NUM_PERIPH-1:0]   periph_set;

   // Action request state.
   ger_ar_state_e           ar_state_ff, nxt_ar_state;
   logic                    lb_req_ff,   nxt_lb_req;
   logic                    pcm_req_ff,  nxt_pcm_req;
   logic [3:0]              ar_set;

   assign wr_cmd     = reg_req.wr && reg_req.addr == OFS_COMMAND;
   assign len_dwords = queue_dwords(len_ff);

   // Timer runs from the command register fields.
   ger_countdown #(
      .W       (RELOAD_WIDTH)
   ) u_countdown (
      .clk     (clk),
      .rst_n   (rst_n_ff),
      .run     (run_ff),
      .reload  (reload_ff),
      .expired (expired)
   );

   // Collect this cycle's events into flag positions; bits 7:0 never reach the queue writer.
   always_comb begin
      set_vec                     = FLAGS_CLEAR;
      set_vec[BIT_PCM_TX_Q]       = core_evt.pcm_tx_entry;
      set_vec[BIT_PCM_RX_Q]       = core_evt.pcm_rx_entry;
      set_vec[BIT_LB_TX_Q]        = core_evt.lb_tx_entry;
      set_vec[BIT_LB_RX_Q]        = core_evt.lb_rx_entry;
      set_vec[BIT_PERIPH_LSB +: NUM_PERIPH] = periph_set;
      set_vec[BIT_EXPIRED]        = expired;
      set_vec[BIT_TX_ASYNC]       = core_evt.tx_async;
      set_vec[BIT_RX_ASYNC]       = core_evt.rx_async;
      set_vec[BIT_LB_OK]          = ar_set[0];
      set_vec[BIT_LB_FAIL]        = ar_set[1];
      set_vec[BIT_PCM_OK]         = ar_set[2];
      set_vec[BIT_PCM_FAIL]       = ar_set[3];
      ack_vec = FLAGS_CLEAR;
      if (reg_req.wr && reg_req.addr == OFS_STATUS) begin
         ack_vec = reg_req.wdata[15:0];
      end
   end

   // Register file next values; a new event wins over a same-cycle acknowledge.
   always_comb begin
      nxt_stat   = ((stat_ff & ~ack_vec) | set_vec) & STAT_IMPL;
      nxt_mask   = mask_ff;
      nxt_base   = base_ff;
      nxt_len    = len_ff;
      nxt_run    = run_ff;
      nxt_reload = reload_ff;
      nxt_rdata  = WORD_ZERO;
      if (wr_cmd) begin
         nxt_run    = reg_req.wdata[CMD_RUN];
         nxt_reload = reg_req.wdata[CMD_RELOAD_LSB +: RELOAD_WIDTH];
      end
      if (reg_req.wr && reg_req.addr == OFS_MASK) begin
         nxt_mask = reg_req.wdata[15:0] & STAT_IMPL;
      end
      if (reg_req.wr && reg_req.addr == OFS_PQ_BASE) begin
         nxt_base = {reg_req.wdata[31:2], DWORD_ALIGN};
      end
      if (reg_req.wr && reg_req.addr == OFS_PQ_LENGTH) begin
         nxt_len = reg_req.wdata[PQ_LEN_W-1:0];
      end
      // Command is write-only and reads back as zero; the acknowledge offset reads status.
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            OFS_STATUS:    nxt_rdata = {16'h0000, stat_ff};
            OFS_MASK:      nxt_rdata = {16'h0000, mask_ff};
            OFS_PQ_BASE:   nxt_rdata = base_ff;
            OFS_PQ_LENGTH: nxt_rdata = {24'h00_0000, len_ff};
            default:       nxt_rdata = WORD_ZERO;
         endcase
      end
   end

   // The interrupt follows registered flags and mask, one cycle behind them.
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         stat_ff   <= FLAGS_CLEAR;
         mask_ff   <= MASK_RESET;
         base_ff   <= WORD_ZERO;
         len_ff    <= '0;
         run_ff    <= 1'b0;
         reload_ff <= '0;
         rdata_ff  <= WORD_ZERO;
         rvalid_ff <= 1'b0;
         inta_n_ff <= 1'b1;
      end else begin
         stat_ff   <= nxt_stat;
         mask_ff   <= nxt_mask;
         base_ff   <= nxt_base;
         len_ff    <= nxt_len;
         run_ff    <= nxt_run;
         reload_ff <= nxt_reload;
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= reg_req.rd;
         inta_n_ff <= ~|(stat_ff & ~mask_ff);
      end
   end

   // Peripheral queue writer: one entry at a time, lowest source first.
   always_comb begin
      nxt_pq_state = pq_state_ff;
      nxt_pend     = pend_ff | periph_evt;
      nxt_sel      = sel_ff;
      nxt_ofs      = ofs_ff;
      nxt_stb      = 1'b0;
      nxt_addr     = addr_ff;
      periph_set   = '0;
      unique case (pq_state_ff)
         PQ_IDLE: begin
            if (pend_ff != '0) begin
               nxt_sel      = pend_ff & (~pend_ff + NUM_PERIPH'(1));
               nxt_addr     = base_ff + {20'h0_0000, ofs_ff, DWORD_ALIGN};
               nxt_stb      = 1'b1;
               nxt_pq_state = PQ_WRITE;
            end
         end
         PQ_WRITE: begin
            nxt_pq_state = PQ_WAIT;
         end
         PQ_WAIT: begin
            if (pq_wr_done) begin
               periph_set   = sel_ff;
               nxt_pend     = (pend_ff & ~sel_ff) | periph_evt;
               nxt_pq_state = PQ_IDLE;
               if ({1'b0, ofs_ff} + 11'h001 >= len_dwords) begin
                  nxt_ofs = '0;
               end else begin
                  nxt_ofs = ofs_ff + PQ_OFS_W'(1);
               end
            end
         end
      endcase
      // A new base or length restarts the queue at its first dword.
      if (reg_req.wr && (reg_req.addr == OFS_PQ_BASE || reg_req.addr == OFS_PQ_LENGTH)) begin
         nxt_ofs = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pq_state_ff <= PQ_IDLE;
         pend_ff     <= '0;
         sel_ff      <= '0;
         ofs_ff      <= '0;
         stb_ff      <= 1'b0;
         addr_ff     <= WORD_ZERO;
      end else begin
         pq_state_ff <= nxt_pq_state;
         pend_ff     <= nxt_pend;
         sel_ff      <= nxt_sel;
         ofs_ff      <= nxt_ofs;
         stb_ff      <= nxt_stb;
         addr_ff     <= nxt_addr;
      end
   end

   // Action requests: only one may be active, the local bus wins a tie.
   always_comb begin
      nxt_ar_state = ar_state_ff;
      nxt_lb_req   = lb_req_ff;
      nxt_pcm_req  = pcm_req_ff;
      ar_set       = 4'h0;
      unique case (ar_state_ff)
         AR_IDLE: begin
            if (wr_cmd && reg_req.wdata[CMD_LB_REQ]) begin
               nxt_lb_req   = 1'b1;
               nxt_ar_state = AR_LB;
            end else if (wr_cmd && reg_req.wdata[CMD_PCM_REQ]) begin
               nxt_pcm_req  = 1'b1;
               nxt_ar_state = AR_PCM;
            end
         end
         AR_LB: begin
            if (lb_action_done) begin
               ar_set[0]    = lb_action_ok;
               ar_set[1]    = !lb_action_ok;
               nxt_lb_req   = 1'b0;
               nxt_ar_state = AR_IDLE;
            end
         end
         AR_PCM: begin
            if (pcm_action_done) begin
               ar_set[2]    = pcm_action_ok;
               ar_set[3]    = !pcm_action_ok;
               nxt_pcm_req  = 1'b0;
               nxt_ar_state = AR_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         ar_state_ff <= AR_IDLE;
         lb_req_ff   <= 1'b0;
         pcm_req_ff  <= 1'b0;
      end else begin
         ar_state_ff <= nxt_ar_state;
         lb_req_ff   <= nxt_lb_req;
         pcm_req_ff  <= nxt_pcm_req;
      end
   end

   assign reg_rdata      = rdata_ff;
   assign reg_rvalid     = rvalid_ff;
   assign pq_wr_stb      = stb_ff;
   assign pq_wr_addr     = addr_ff;
   assign pq_wr_src      = sel_ff;
   assign lb_action_req  = lb_req_ff;
   assign pcm_action_req = pcm_req_ff;
   assign inta_n         = inta_n_ff;

   sequence seq_lb_start;
      ar_state_ff == AR_IDLE && wr_cmd && reg_req.wdata[CMD_LB_REQ];
   endsequence

   sequence seq_lb_finish;
      ar_state_ff == AR_LB && lb_action_done;
   endsequence

   AST_EVENT_FLAGS_SET: assert property (
      @(posedge clk) disable iff (!rst_n_ff)
      core_evt.pcm_tx_entry |=> stat_ff[BIT_PCM_TX_Q])
      else $error("Transmit queue event did not set its flag.");

   AST_UNMASKED_RAISES_INTA: assert property (
      @(posedge clk) disable iff (!rst_n_ff)
      (|(stat_ff & ~mask_ff)) |=> !inta_n_ff)
      else $error("Unmasked flag did not assert the interrupt.");

   AST_ACK_CLEARS_FLAG: assert property (
      @(posedge clk) disable iff (!rst_n_ff)
      (ack_vec[BIT_EXPIRED] && !expired) |=>
      (!stat_ff[BIT_EXPIRED] ##1 (inta_n_ff == !$past(|(stat_ff & ~mask_ff)))))
      else $error("Acknowledge did not clear the timer flag.");

   AST_MASKED_FLAG_STILL_SETS: assert property (
      @(posedge clk) disable iff (!rst_n_ff)
      (expired && mask_ff[BIT_EXPIRED] && stat_ff == FLAGS_CLEAR) |=>
      (stat_ff[BIT_EXPIRED] ##1 (inta_n_ff == !$past(|(stat_ff & ~mask_ff)))))
      else $error("Masked event misbehaved.");

   AST_FRAME_ASYNC_FLAG: assert property (
      @(posedge clk) disable iff (!rst_n_ff)
      core_evt.rx_async |=> stat_ff[BIT_RX_ASYNC])
      else $error("Receive frame async flag not set.");

   AST_LB_ONE_RESULT: assert property (
      @(posedge clk) disable iff (!rst_n_ff)
      seq_lb_finish |=> (stat_ff[BIT_LB_OK] != stat_ff[BIT_LB_FAIL] || ($past(stat_ff[BIT_LB_OK]) || $past(stat_ff[BIT_LB_FAIL]))))
      else $error("Local bus request ended without one result flag.");

   AST_ONE_REQUEST_ACTIVE: assert property (
      @(posedge clk) disable iff (!rst_n_ff)
      seq_lb_start |=> (lb_req_ff && !pcm_req_ff) ##0 (ar_state_ff == AR_LB))
      else $error("Local bus action request did not start alone.");

   AST_BASE_ALIGNED: assert property (
      @(posedge clk) disable iff (!rst_n_ff)
      base_ff[1:0] == DWORD_ALIGN && addr_ff[1:0] == DWORD_ALIGN)
      else $error("Queue address not dword aligned.");

   AST_POINTER_WRAPS: assert property (
      @(posedge clk) disable iff (!rst_n_ff)
      (pq_state_ff == PQ_WAIT && pq_wr_done && !reg_req.wr && len_ff == '0 && ofs_ff == '1)
      |=> ofs_ff == '0)
      else $error("Queue pointer did not wrap at 1024 dwords.");

   AST_POINTER_ADVANCES: assert property (
      @(posedge clk) disable iff (!rst_n_ff)
      (pq_state_ff == PQ_WAIT && pq_wr_done && !reg_req.wr && {1'b0, ofs_ff} + 11'h001 < len_dwords)
      |=> ofs_ff == $past(ofs_ff) + PQ_OFS_W'(1))
      else $error("Queue pointer did not advance.");

endmodule

// File: verif/ger_far_model.sv
// Far-side responder for queue entry writes and action request handshakes.
// Assumes the bench sets the answer delay (at least 1) and the result.
`timescale 1ns/10ps
module ger_far_model (
   // Clock.
   input  wire logic       clk,
   // Queue writer.
   input  wire logic       pq_wr_stb,
   output logic            pq_wr_done,
   // Action handshakes.
   input  wire logic       lb_action_req,
   output logic            lb_action_done,
   output logic            lb_action_ok,
   input  wire logic       pcm_action_req,
   output logic            pcm_action_done,
   output logic            pcm_action_ok,
   // Behaviour chosen by the bench.
   input  wire logic [3:0] dly,
   input  wire logic       ok
);
   // Outputs start idle; the result line is not valid outside a done pulse.
   initial begin
      pq_wr_done = 1'b0;
      lb_action_done = 1'b0;
      lb_action_ok = 1'b0;
      pcm_action_done = 1'b0;
      pcm_action_ok = 1'b0;
   end

   // Entry write ends some cycles after the strobe, never in the strobe cycle.
   always @(posedge clk) begin
      if (pq_wr_stb === 1'b1) begin
         repeat (dly) @(posedge clk);
         pq_wr_done <= 1'b1;
         @(posedge clk);
         pq_wr_done <= 1'b0;
      end
   end

   // Result shows its inverse after done, so a late sample is caught.
   always @(posedge clk) begin
      if (lb_action_req === 1'b1) begin
         repeat (dly) @(posedge clk);
         lb_action_ok   <= ok;
         lb_action_done <= 1'b1;
         @(posedge clk);
         lb_action_done <= 1'b0;
         lb_action_ok   <= ~ok;
         while (lb_action_req === 1'b1) @(posedge clk);
      end
   end

   // Same handshake for the serial PCM core.
   always @(posedge clk) begin
      if (pcm_action_req === 1'b1) begin
         repeat (dly) @(posedge clk);
         pcm_action_ok   <= ok;
         pcm_action_done <= 1'b1;
         @(posedge clk);
         pcm_action_done <= 1'b0;
         pcm_action_ok   <= ~ok;
         while (pcm_action_req === 1'b1) @(posedge clk);
      end
   end
endmodule

// File: verif/global_event_and_command_regs_tb_top.sv
// Self-checking bench for the global event, command and queue registers.
// Assumes the far-side model answers queue writes and action requests.
`timescale 1ns/10ps
module global_event_and_command_regs_tb_top;
   import ger_pkg::*;
   logic          clk, reset_n, rvalid, stb, done, inta_n, far_ok;
   logic          lb_req, lb_done, lb_ok, pcm_req, pcm_done, pcm_ok;
   ger_reg_req_s  req;
   ger_core_evt_s evt;
   logic [31:0]   rdata, addr, exp;
   logic [3:0]    pevt, src, dly;
   int            num_errors, checks, stb_cnt, n;
   int            ebit[6] = '{4, 5, 12, 13, 14, 15};

   ger_global_regs uut (.clk(clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .core_evt(evt), .periph_evt(pevt), .pq_wr_stb(stb),
      .pq_wr_addr(addr), .pq_wr_src(src), .pq_wr_done(done), .lb_action_req(lb_req),
      .lb_action_done(lb_done), .lb_action_ok(lb_ok), .pcm_action_req(pcm_req),
      .pcm_action_done(pcm_done), .pcm_action_ok(pcm_ok), .inta_n(inta_n));
   ger_far_model far (.clk(clk), .pq_wr_stb(stb), .pq_wr_done(done),
      .lb_action_req(lb_req), .lb_action_done(lb_done), .lb_action_ok(lb_ok),
      .pcm_action_req(pcm_req), .pcm_action_done(pcm_done), .pcm_action_ok(pcm_ok),
      .dly(dly), .ok(far_ok));

   // Clock and a count of queue strobes.
   initial clk = 1'b0;
   always #25 clk = ~clk;
   always @(posedge clk) if (stb === 1'b1) stb_cnt++;

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   // Read data only counts while the valid flag stands.
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      @(posedge clk);
      req.rd   <= 1'b1;
      req.addr <= a;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk((rvalid === 1'b1) ? rdata : 32'hdead_beef, want);
   endtask

   task automatic pulse(input logic [5:0] e, input logic [3:0] p);
      @(posedge clk);
      evt  <= ger_core_evt_s'(e);
      pevt <= p;
      @(posedge clk);
      evt  <= '0;
      pevt <= 4'h0;
   endtask

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // A hang is cut short well past the expected run length.
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      end_of_test;
   end

   initial begin
      req = '0;
      evt = '0;
      pevt = 4'h0;
      dly = 4'h2;
      far_ok = 1'b1;
      reset_n = 1'b0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(32'(inta_n), 32'h0000_0001);
      rd(OFS_MASK, 32'h0000_ff7f);
      rd(OFS_STATUS, 32'h0000_0000);
      rd(OFS_COMMAND, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      // Every core event sets its own flag; all masked, so no interrupt.
      exp = 32'h0000_0000;
      for (int i = 0; i < 6; i++) begin
         pulse(6'(1 << i), 4'h0);
         exp = exp | (32'h0000_0001 << ebit[i]);
         rd(OFS_STATUS, exp);
      end
      chk(32'(inta_n), 32'h0000_0001);
      wr(OFS_STATUS, 32'h0000_ffff);
      rd(OFS_STATUS, 32'h0000_0000);
      // Masked event flags only; unmasked one drives the line two cycles on.
      wr(OFS_MASK, 32'h0000_8000);
      rd(OFS_MASK, 32'h0000_8000);
      pulse(6'h20, 4'h0);
      repeat (3) @(posedge clk);
      #1;
      chk(32'(inta_n), 32'h0000_0001);
      rd(OFS_STATUS, 32'h0000_8000);
      wr(OFS_STATUS, 32'h0000_ffff);
      wr(OFS_MASK, 32'h0000_0000);
      pulse(6'h20, 4'h0);
      #1;
      chk(32'(inta_n), 32'h0000_0001);
      @(posedge clk);
      #1;
      chk(32'(inta_n), 32'h0000_0000);
      wr(OFS_STATUS, 32'h0000_8000);
      @(posedge clk);
      #1;
      chk(32'(inta_n), 32'h0000_0001);
      // Both requests, ending in success and in failure.
      for (int k = 0; k < 4; k++) begin
         far_ok <= ~k[0];
         wr(OFS_COMMAND, k[1] ? 32'h0000_0002 : 32'h0000_0001);
         repeat (8) @(posedge clk);
         rd(OFS_STATUS, 32'h0000_0001 << (2 * k[1] + k[0]));
         wr(OFS_STATUS, 32'h0000_000f);
      end
      // A second request while one is active is dropped.
      dly <= 4'h8;
      far_ok <= 1'b1;
      wr(OFS_COMMAND, 32'h0000_0001);
      wr(OFS_COMMAND, 32'h0000_0002);
      #1;
      chk(32'({lb_req, pcm_req}), 32'h0000_0001);
      repeat (14) @(posedge clk);
      rd(OFS_STATUS, 32'h0000_0001);
      wr(OFS_STATUS, 32'h0000_000f);
      // Both bits at once: only the local bus request starts.
      dly <= 4'h2;
      wr(OFS_COMMAND, 32'h0000_0003);
      #1;
      chk(32'({lb_req, pcm_req}), 32'h0000_0002);
      repeat (8) @(posedge clk);
      rd(OFS_STATUS, 32'h0000_0004);
      wr(OFS_STATUS, 32'h0000_000f);
      // Timer with reload 5 underflows every six cycles and keeps running.
      // Its flag is masked here, so the line must stay released.
      wr(OFS_MASK, 32'h0000_0040);
      wr(OFS_COMMAND, 32'h0005_0010);
      repeat (10) @(posedge clk);
      rd(OFS_STATUS, 32'h0000_0040);
      chk(32'(inta_n), 32'h0000_0001);
      wr(OFS_STATUS, 32'h0000_0040);
      repeat (8) @(posedge clk);
      rd(OFS_STATUS, 32'h0000_0040);
      wr(OFS_COMMAND, 32'h0000_0000);
      wr(OFS_STATUS, 32'h0000_0040);
      repeat (12) @(posedge clk);
      rd(OFS_STATUS, 32'h0000_0000);
      chk(32'(stb_cnt), 32'h0000_0000);
      // Queue walk past its end, for a short length and for the maximum.
      wr(OFS_PQ_BASE, 32'h0000_1003);
      rd(OFS_PQ_BASE, 32'h0000_1000);
      for (int l = 0; l < 2; l++) begin
         wr(OFS_PQ_LENGTH, l ? 32'h0000_0000 : 32'h0000_0101);
         rd(OFS_PQ_LENGTH, l ? 32'h0000_0000 : 32'h0000_0001);
         n = l ? 1024 : 4;
         for (int i = 0; i <= n; i++) begin
            pulse(6'h00, 4'(1 << (i % 4)));
            for (int t = 0; t < 20 && stb !== 1'b1; t++) begin
               @(posedge clk);
               #1;
            end
            chk(32'(stb), 32'h0000_0001);
            chk(addr, 32'h0000_1000 + 32'(4 * (i % n)));
            chk(32'(src), 32'(1 << (i % 4)));
            repeat (dly + 2) @(posedge clk);
         end
      end
      rd(OFS_STATUS, 32'h0000_0f00);
      end_of_test;
   end
endmodule
